/* File: inc/sbpt_pkg.sv */
`default_nettype none

package sbpt_pkg;

  // ****************************************************************
  // Trigger modes and configuration
  // ****************************************************************
  typedef enum logic [2:0] {
    SBPT_MODE_OFF,
    SBPT_MODE_I2C_START,
    SBPT_MODE_I2C_RESTART,
    SBPT_MODE_I2C_NACK,
    SBPT_MODE_I2C_ADDR10_WR,
    SBPT_MODE_SPI_PATTERN
  } sbpt_mode_e;

  // SPI pattern configuration travels as one bundle.
  typedef struct packed {
    logic [31:0] care;
    logic [31:0] value;
    logic [5:0] length;
    logic rising_edge;
    logic use_idle_framing;
    logic active_high_select_framing;
    logic [15:0] idle_cycles;
  } sbpt_spi_cfg_s;

  // Ten-bit write match: address, first data byte, and a mask for each.
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
    logic [17:0] care;
  } sbpt_i2c_cfg_s;

  localparam int SBPT_SYNC_STAGES = 2;
  localparam logic [5:0] SBPT_PAT_MIN = 6'h04;
  localparam logic [5:0] SBPT_PAT_MAX = 6'h20;
  localparam logic [3:0] SBPT_BYTE_BITS = 4'h8;
  localparam logic [3:0] SBPT_ACK_SLOT = 4'h9;
  localparam logic [4:0] SBPT_ADDR10_PREFIX = 5'h1e;
  localparam logic [1:0] SBPT_SYNC_RESET = 2'h0;

endpackage

`default_nettype wire

/* File: rtl/sbpt_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Two-stage synchroniser with a registered copy for edge finding.
// ****************************************************************
module sbpt_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out,
  output logic q_prev_out
);
  import sbpt_pkg::*;

  logic [SBPT_SYNC_STAGES-1:0] sync_reg;

  // Only the second stage is read; the first may be metastable.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_reg <= SBPT_SYNC_RESET;
      q_prev_out <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[0], d_in};
      q_prev_out <= sync_reg[1];
    end
  end

  assign q_out = sync_reg[1];
endmodule

`default_nettype wire

/* File: rtl/sbpt_top.sv */
// Notes on behaviour
// - A data fall while the two-wire clock is high is a start and fires the start trigger.
// - In restart mode a second start seen before any stop fires the trigger.
// - In missing-acknowledge mode any high acknowledge slot fires, whatever the frame length.
// - In ten-bit write mode a write whose address and data match the masked pattern fires.
// - SPI data is sampled on the chosen clock edge and only inside a framing period.
// - The pattern is 4 to 32 bits long with each bit low, high or don't care.
// - Framing may come from the select line as active high or active low.
// - Framing may instead start after the SPI clock has been idle for a set time.
// - On the Nth active edge of a frame the trigger fires if every cared sampled bit matches.
`timescale 1ns/1ns
`default_nettype none

module sbpt_top (
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire sbpt_pkg::sbpt_mode_e MODE_IN,
  input wire sbpt_pkg::sbpt_spi_cfg_s SPI_CFG_IN,
  input wire sbpt_pkg::sbpt_i2c_cfg_s I2C_CFG_IN,
  input wire logic I2C_SCL_IN,
  input wire logic I2C_SDA_IN,
  input wire logic SPI_SCLK_IN,
  input wire logic SPI_DATA_IN,
  input wire logic SPI_SEL_IN,
  output logic TRIGGER_OUT,
  output logic I2C_BUSY_OUT,
  output logic SPI_FRAME_OUT
);
  import sbpt_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic scl, scl_p, sda, sda_p, sck, sck_p, sdi, sdi_p, sel, sel_p;

  // Every bus line crosses two flops before logic sees it.
  sbpt_sync u_scl (.clk_in(REF_CLK_IN), .rst_in(SYS_RST_IN), .d_in(I2C_SCL_IN),
    .q_out(scl), .q_prev_out(scl_p));
  sbpt_sync u_sda (.clk_in(REF_CLK_IN), .rst_in(SYS_RST_IN), .d_in(I2C_SDA_IN),
    .q_out(sda), .q_prev_out(sda_p));
  sbpt_sync u_sck (.clk_in(REF_CLK_IN), .rst_in(SYS_RST_IN), .d_in(SPI_SCLK_IN),
    .q_out(sck), .q_prev_out(sck_p));
  sbpt_sync u_sdi (.clk_in(REF_CLK_IN), .rst_in(SYS_RST_IN), .d_in(SPI_DATA_IN),
    .q_out(sdi), .q_prev_out(sdi_p));
  sbpt_sync u_sel (.clk_in(REF_CLK_IN), .rst_in(SYS_RST_IN), .d_in(SPI_SEL_IN),
    .q_out(sel), .q_prev_out(sel_p));

  // ****************************************************************
  // Two-wire condition detection
  // ****************************************************************
  logic i2c_start, i2c_stop, scl_rise;

  // Clock must be high both before and after the data edge.
  assign i2c_start = scl && scl_p && sda_p && !sda;
  assign i2c_stop = scl && scl_p && !sda_p && sda;
  assign scl_rise = scl && !scl_p;

  // ****************************************************************
  // Two-wire byte tracker
  // ****************************************************************
  logic in_frame_reg, seen_start_reg, addr10_reg, write_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [1:0] byte_idx_reg;
  logic [7:0] addr_lo_reg;
  logic [1:0] addr_hi_reg;
  logic [8:0] shift_next;
  logic i2c_fire;

  assign shift_next = {shift_reg, sda};

  // Bits are taken on the clock's rising edge; the ninth is the acknowledge slot.
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      in_frame_reg <= 1'b0;
      seen_start_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_idx_reg <= 2'h0;
      addr10_reg <= 1'b0;
      write_reg <= 1'b0;
      addr_lo_reg <= 8'h00;
      addr_hi_reg <= 2'h0;
    end else if (i2c_stop) begin
      in_frame_reg <= 1'b0;
      seen_start_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= 2'h0;
      addr10_reg <= 1'b0;
    end else if (i2c_start) begin
      // A repeated start restarts byte counting but keeps the frame open.
      in_frame_reg <= 1'b1;
      seen_start_reg <= 1'b1;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= 2'h0;
      addr10_reg <= 1'b0;
    end else if (in_frame_reg && scl_rise) begin
      if (bit_cnt_reg == SBPT_ACK_SLOT - 4'h1) begin
        bit_cnt_reg <= 4'h0;
        if (byte_idx_reg != 2'h3) begin
          byte_idx_reg <= byte_idx_reg + 2'h1;
        end
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg <= shift_next[7:0];
        if (bit_cnt_reg == SBPT_BYTE_BITS - 4'h1 && byte_idx_reg == 2'h0) begin
          addr10_reg <= shift_next[7:3] == SBPT_ADDR10_PREFIX;
          write_reg <= !sda;
          // The shifter moves on, so the two high address bits are kept here.
          addr_hi_reg <= shift_next[2:1];
        end
        if (bit_cnt_reg == SBPT_BYTE_BITS - 4'h1 && byte_idx_reg == 2'h1) begin
          addr_lo_reg <= shift_next[7:0];
        end
      end
    end
  end

  // Trigger decision for the two-wire modes.
  always_comb begin
    i2c_fire = 1'b0;
    case (MODE_IN)
      SBPT_MODE_I2C_START: i2c_fire = i2c_start;
      SBPT_MODE_I2C_RESTART: i2c_fire = i2c_start && seen_start_reg;
      SBPT_MODE_I2C_NACK: begin
        // A high data line in the ninth clock is a missing acknowledge.
        i2c_fire = in_frame_reg && scl_rise && sda && bit_cnt_reg == SBPT_ACK_SLOT - 4'h1;
      end
      SBPT_MODE_I2C_ADDR10_WR: begin
        // Fires as the first data byte after a ten-bit write address completes.
        i2c_fire = in_frame_reg && scl_rise && addr10_reg && write_reg &&
          byte_idx_reg == 2'h2 && bit_cnt_reg == SBPT_BYTE_BITS - 4'h1 &&
          ((({addr_hi_reg, addr_lo_reg, shift_next[7:0]} ^
             {I2C_CFG_IN.addr, I2C_CFG_IN.data}) & I2C_CFG_IN.care) == 18'h0_0000);
      end
      default: i2c_fire = 1'b0;
    endcase
  end

  // ****************************************************************
  // SPI framing
  // ****************************************************************
  logic sel_active, sck_edge, sck_active_edge, frame_reg, frame_end;
  logic spi_done, spi_fire;
  logic [15:0] idle_cnt_reg;

  assign sel_active = SPI_CFG_IN.active_high_select_framing ? sel : !sel;
  assign sck_edge = sck ^ sck_p;
  assign sck_active_edge = SPI_CFG_IN.rising_edge ? (sck && !sck_p) : (!sck && sck_p);

  // Idle counter; saturates so a long quiet bus never wraps.
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      idle_cnt_reg <= 16'h0000;
    end else if (sck_edge) begin
      idle_cnt_reg <= 16'h0000;
    end else if (idle_cnt_reg != 16'hffff) begin
      idle_cnt_reg <= idle_cnt_reg + 16'h0001;
    end
  end

  // Self framing opens after the idle time and ends when the pattern completes.
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      frame_reg <= 1'b0;
    end else if (!SPI_CFG_IN.use_idle_framing) begin
      frame_reg <= sel_active;
    end else if (!frame_reg && idle_cnt_reg >= SPI_CFG_IN.idle_cycles) begin
      frame_reg <= 1'b1;
    end else if (frame_reg && spi_done) begin
      frame_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // SPI pattern matcher
  // ****************************************************************
  logic [5:0] edge_cnt_reg, pat_len;
  logic [31:0] sampled_reg, sampled_next;

  // Clamp the configured length into the legal span.
  assign pat_len = SPI_CFG_IN.length < SBPT_PAT_MIN ? SBPT_PAT_MIN :
    (SPI_CFG_IN.length > SBPT_PAT_MAX ? SBPT_PAT_MAX : SPI_CFG_IN.length);
  assign sampled_next = {sampled_reg[30:0], sdi};
  assign frame_end = !frame_reg || (!SPI_CFG_IN.use_idle_framing && !sel_active);
  assign spi_done = frame_reg && sck_active_edge && edge_cnt_reg == pat_len - 6'h01;
  // First bit lands in the highest used position; uncared bits are ignored.
  assign spi_fire = spi_done && MODE_IN == SBPT_MODE_SPI_PATTERN &&
    (((sampled_next ^ SPI_CFG_IN.value) & SPI_CFG_IN.care &
      (32'hffff_ffff >> (6'h20 - pat_len))) == 32'h0000_0000);

  // Edge counting restarts whenever framing drops.
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      edge_cnt_reg <= 6'h00;
      sampled_reg <= 32'h0000_0000;
    end else if (frame_end) begin
      edge_cnt_reg <= 6'h00;
      sampled_reg <= 32'h0000_0000;
    end else if (sck_active_edge) begin
      sampled_reg <= sampled_next;
      // After the Nth edge further bits are ignored until the next frame.
      edge_cnt_reg <= spi_done ? 6'h3f : (edge_cnt_reg == 6'h3f ? 6'h3f : edge_cnt_reg + 6'h01);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // All outputs are registered; trigger is high for one cycle per event.
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      TRIGGER_OUT <= 1'b0;
      I2C_BUSY_OUT <= 1'b0;
      SPI_FRAME_OUT <= 1'b0;
    end else begin
      TRIGGER_OUT <= i2c_fire || spi_fire;
      I2C_BUSY_OUT <= in_frame_reg;
      SPI_FRAME_OUT <= frame_reg;
    end
  end
endmodule

`default_nettype wire

/* File: tb/sbpt_monitor.sv */
`timescale 1ns/1ns
`default_nettype none

// ********
// Port checker for the serial trigger.
// ********
module sbpt_monitor (
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire sbpt_pkg::sbpt_mode_e MODE_IN,
  input wire sbpt_pkg::sbpt_spi_cfg_s SPI_CFG_IN,
  input wire logic I2C_SCL_IN,
  input wire logic I2C_SDA_IN,
  input wire logic SPI_SCLK_IN,
  input wire logic SPI_DATA_IN,
  input wire logic SPI_SEL_IN,
  input wire logic TRIGGER_OUT,
  input wire logic I2C_BUSY_OUT,
  input wire logic SPI_FRAME_OUT
);
  import sbpt_pkg::*;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  logic [4:0] pins_reg;
  logic [3:0] quiet_reg;
  wire logic [4:0] pins = {I2C_SCL_IN, I2C_SDA_IN, SPI_SCLK_IN, SPI_DATA_IN, SPI_SEL_IN};
  wire logic sel_on = MODE_IN == SBPT_MODE_SPI_PATTERN && !SPI_CFG_IN.use_idle_framing;

  // Cycles since a bus pin last moved; saturates so a long idle cannot wrap.
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      pins_reg <= 5'h00;
      quiet_reg <= 4'hf;
    end else begin
      pins_reg <= pins;
      quiet_reg <= (pins != pins_reg) ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hf};
    end
  end

  a_pulse_single: assert property (TRIGGER_OUT |=> !TRIGGER_OUT)
    else $error("trigger pulse too long");
  a_start_fires: assert property (MODE_IN == SBPT_MODE_I2C_START && $fell(I2C_SDA_IN)
    && I2C_SCL_IN |-> ##[3:5] TRIGGER_OUT) else $error("start not triggered");
  a_busy_start: assert property ($fell(I2C_SDA_IN) && I2C_SCL_IN |-> ##[3:5] I2C_BUSY_OUT)
    else $error("busy not raised by start");
  a_stop_clears: assert property ($rose(I2C_SDA_IN) && I2C_SCL_IN |-> ##[3:5] !I2C_BUSY_OUT)
    else $error("busy not cleared by stop");
  a_off_silent: assert property (MODE_IN == SBPT_MODE_OFF |-> !TRIGGER_OUT)
    else $error("trigger while off");
  a_sel_frame: assert property ((sel_on && SPI_SEL_IN == SPI_CFG_IN.active_high_select_framing)[*4]
    |=> SPI_FRAME_OUT) else $error("frame missing while selected");
  a_sel_noframe: assert property ((sel_on && SPI_SEL_IN != SPI_CFG_IN.active_high_select_framing)[*4]
    |=> !SPI_FRAME_OUT) else $error("frame while deselected");
  a_trig_cause: assert property (TRIGGER_OUT |-> quiet_reg <= 4'h7)
    else $error("trigger without recent bus edge");

  cover property (TRIGGER_OUT && MODE_IN == SBPT_MODE_I2C_NACK);
  cover property (TRIGGER_OUT && MODE_IN == SBPT_MODE_I2C_ADDR10_WR);
  cover property (TRIGGER_OUT && MODE_IN == SBPT_MODE_SPI_PATTERN);
endmodule
`default_nettype wire

/* File: tb/sbpt_bus_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ********
// Observed bus: a two-wire master with its slaves, and an SPI master.
// ********
module sbpt_bus_model (
  input wire logic clk_in,
  input wire sbpt_pkg::sbpt_spi_cfg_s cfg_in,
  output logic scl_out,
  output logic sda_out,
  output logic sclk_out,
  output logic data_out,
  output logic sel_out
);
  import sbpt_pkg::*;

  // Two-wire lines idle high through their pull-ups.
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    sclk_out = 1'b0;
    data_out = 1'b0;
    sel_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Data moves only while the clock is low, so no false start or stop appears.
  task automatic i2c_bit(input logic b);
    tick(2);
    sda_out <= b;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    scl_out <= 1'b0;
  endtask

  task automatic i2c_start();
    tick(2);
    sda_out <= 1'b1;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_out <= 1'b0;
    tick(4);
    scl_out <= 1'b0;
  endtask

  task automatic i2c_stop();
    tick(2);
    sda_out <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_out <= 1'b1;
    tick(4);
  endtask

  // A refused byte leaves the slot to the pull-up, which reads as no acknowledge.
  task automatic i2c_byte(input logic [7:0] b, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(b[i]);
    end
    i2c_bit(!ack);
    tick(2);
    sda_out <= 1'b1;
  endtask

  // Sends v[n-1] first; select framing gets a setup gap, idle framing a quiet gap.
  task automatic spi_frame(input logic [31:0] v, input int n);
    logic idle;
    tick(1);
    idle = !cfg_in.rising_edge;
    sclk_out <= idle;
    sel_out <= !cfg_in.active_high_select_framing;
    tick(cfg_in.use_idle_framing ? int'(cfg_in.idle_cycles) + 4 : 4);
    if (!cfg_in.use_idle_framing) begin
      sel_out <= cfg_in.active_high_select_framing;
    end
    tick(4);
    for (int i = n - 1; i >= 0; i--) begin
      data_out <= v[i];
      tick(4);
      sclk_out <= !idle;
      tick(4);
      sclk_out <= idle;
    end
    tick(4);
    sel_out <= !cfg_in.active_high_select_framing;
    data_out <= !data_out;
    tick(4);
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %0h expected %0h", $time, g, e); end end

// ********
// Self-checking bench for the serial trigger.
// ********
module testbench;
  import sbpt_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  sbpt_mode_e mode = SBPT_MODE_OFF;
  sbpt_spi_cfg_s spi_cfg = '{32'hffff_ffff, 32'ha5c3_96f0, 6'h04, 1'b1, 1'b0, 1'b1, 16'h0010};
  sbpt_i2c_cfg_s i2c_cfg = '0;
  logic scl, sda, sclk, sdata, sel, trig, busy, frame;
  int mismatches = 0;
  int check_count = 0;
  int trig_count = 0;
  int base = 0;
  int cycles = 0;

  sbpt_top i_dut (.REF_CLK_IN(ref_clk), .SYS_RST_IN(sys_rst), .MODE_IN(mode),
    .SPI_CFG_IN(spi_cfg), .I2C_CFG_IN(i2c_cfg), .I2C_SCL_IN(scl), .I2C_SDA_IN(sda),
    .SPI_SCLK_IN(sclk), .SPI_DATA_IN(sdata), .SPI_SEL_IN(sel), .TRIGGER_OUT(trig),
    .I2C_BUSY_OUT(busy), .SPI_FRAME_OUT(frame));
  sbpt_bus_model i_bus (.clk_in(ref_clk), .cfg_in(spi_cfg), .scl_out(scl), .sda_out(sda),
    .sclk_out(sclk), .data_out(sdata), .sel_out(sel));

  always #50 ref_clk = ~ref_clk;

  // Pulses are tallied so scenarios compare totals; a hang ends the run here.
  always @(posedge ref_clk) begin
    cycles++;
    if (trig === 1'b1) begin
      trig_count++;
    end
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // The small delay lets registered outputs settle before they are read.
  task automatic arm(input sbpt_mode_e m);
    @(posedge ref_clk);
    mode <= m;
    tick(4);
    #10;
    base = trig_count;
  endtask

  task automatic expect_trig(input int n);
    tick(8);
    #10;
    `CHK(trig_count - base, n)
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic w10(input logic [9:0] a, input logic [7:0] d);
    i_bus.i2c_start();
    i_bus.i2c_byte({SBPT_ADDR10_PREFIX, a[9:8], 1'b0}, 1'b1);
    i_bus.i2c_byte(a[7:0], 1'b1);
    i_bus.i2c_byte(d, 1'b1);
    i_bus.i2c_stop();
  endtask

  task automatic spi_case(input logic [5:0] len, input logic [2:0] fmt,
      input logic [31:0] care, input logic [31:0] v, input int n, input int exp);
    @(posedge ref_clk);
    spi_cfg.length <= len;
    {spi_cfg.rising_edge, spi_cfg.active_high_select_framing, spi_cfg.use_idle_framing} <= fmt;
    spi_cfg.care <= care;
    arm(SBPT_MODE_SPI_PATTERN);
    i_bus.spi_frame(v, n);
    expect_trig(exp);
  endtask

  // Scenarios run in order; each judges its own outcome.
  initial begin
    tick(4);
    sys_rst <= 1'b0;
    tick(4);
    arm(SBPT_MODE_OFF);
    w10(10'h2a5, 8'h3c);
    expect_trig(0);
    arm(SBPT_MODE_I2C_START);
    i_bus.i2c_start();
    tick(2);
    #10;
    `CHK(busy, 1'b1)
    i_bus.i2c_byte(8'h50, 1'b1);
    i_bus.i2c_stop();
    #10;
    `CHK(busy, 1'b0)
    expect_trig(1);
    arm(SBPT_MODE_I2C_RESTART);
    i_bus.i2c_start();
    i_bus.i2c_byte(8'ha0, 1'b1);
    w10(10'h155, 8'h00);
    i_bus.i2c_start();
    i_bus.i2c_stop();
    expect_trig(1);
    arm(SBPT_MODE_I2C_NACK);
    i_bus.i2c_start();
    i_bus.i2c_byte(8'h50, 1'b1);
    i_bus.i2c_byte(8'h41, 1'b0);
    i_bus.i2c_byte(8'hff, 1'b0);
    i_bus.i2c_stop();
    expect_trig(2);
    @(posedge ref_clk);
    i2c_cfg <= '{addr: 10'h2a5, data: 8'h3c, care: 18'h3_ffff};
    arm(SBPT_MODE_I2C_ADDR10_WR);
    w10(10'h2a5, 8'h3c);
    w10(10'h2a5, 8'h3d);
    w10(10'h1a5, 8'h3c);
    expect_trig(1);
    @(posedge ref_clk);
    i2c_cfg.care <= 18'h3_ff00;
    arm(SBPT_MODE_I2C_ADDR10_WR);
    w10(10'h2a5, 8'h00);
    expect_trig(1);
    spi_case(6'h04, 3'b110, 32'hffff_ffff, 32'ha5c3_96f0, 4, 1);
    spi_case(6'h20, 3'b000, 32'hffff_ffff, 32'ha5c3_96f0, 32, 1);
    spi_case(6'h08, 3'b101, 32'hffff_ffff, 32'ha5c3_96f0, 8, 1);
    spi_case(6'h08, 3'b010, 32'hffff_ffff, 32'ha5c3_96f1, 8, 0);
    spi_case(6'h08, 3'b100, 32'hffff_ffff, 32'ha5c3_96f0, 5, 0);
    spi_case(6'h08, 3'b110, 32'hffff_fffe, 32'ha5c3_96f1, 8, 1);
    summarize();
  end
endmodule

bind sbpt_top sbpt_monitor i_mon (.REF_CLK_IN(REF_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .MODE_IN(MODE_IN), .SPI_CFG_IN(SPI_CFG_IN), .I2C_SCL_IN(I2C_SCL_IN), .I2C_SDA_IN(I2C_SDA_IN),
  .SPI_SCLK_IN(SPI_SCLK_IN), .SPI_DATA_IN(SPI_DATA_IN), .SPI_SEL_IN(SPI_SEL_IN),
  .TRIGGER_OUT(TRIGGER_OUT), .I2C_BUSY_OUT(I2C_BUSY_OUT), .SPI_FRAME_OUT(SPI_FRAME_OUT));
`default_nettype wire
